// >>> shared/oitc_pkg.sv
// Overview of operation
// - Foldback on CC turns the output off once CV-to-CC holds for the delay.
// - Foldback on CV turns the output off once CC-to-CV holds for the delay.
// - Foldback can be disabled, and disabled is the reset default.
// - In latch mode a low disable input turns the output off and it stays off.
// - A latched disable clears only after release, clear key, then output on.
// - In living mode the output is off while disable is low, then restored.
// - The trigger source is panel keys (default), bus command or external pin.
// - With external source and the pin set to input, each low pulse on the pin starts one list run.
// - With the pin as output, an accepted key or bus trigger pulses it low.
// - With the pin set to input and external source, a received low pulse is a trigger event.
// - A lock key toggles the lock; locked keys but on/off and shift are ignored.
// - With discharge on (default), the internal load is on while output is off.
package oitc_pkg;
  typedef enum logic [1:0] {OITC_FB_OFF, OITC_FB_CC, OITC_FB_CV} oitc_fb_t;
  typedef enum logic [1:0] {OITC_INH_OFF, OITC_INH_LATCH, OITC_INH_LIVE}
    oitc_inh_t;
  typedef enum logic [1:0] {OITC_SRC_KEY, OITC_SRC_BUS, OITC_SRC_EXT}
    oitc_src_t;
  localparam int unsigned OITC_CLK_HZ      = 20_000_000;
  localparam int unsigned OITC_STEP_US     = 1_000;
  localparam int unsigned OITC_STEP_CYC    = OITC_CLK_HZ / 1_000_000
                                           * OITC_STEP_US;
  localparam int unsigned OITC_DLY_MAX_MS  = 10_000;
  localparam int unsigned OITC_PULSE_US    = 10;
  localparam int unsigned OITC_PULSE_CYC   = OITC_CLK_HZ / 1_000_000
                                           * OITC_PULSE_US;
  localparam logic [13:0] OITC_DLY_RST     = 14'h0000;
  localparam logic        OITC_DISCH_RST   = 1'b1;
endpackage

// >>> verilog/oitc_ctrl.sv
`timescale 1ns/1ns
module oitc_ctrl
  import oitc_pkg::*;
#(
  parameter int unsigned STEP_CYC  = OITC_STEP_CYC,
  parameter int unsigned PULSE_CYC = OITC_PULSE_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire oitc_fb_t    fb_mode_i,
  input  wire logic [13:0] fb_delay_ms_i,
  input  wire logic        reg_cc_i,
  input  wire oitc_inh_t   inh_mode_i,
  input  wire logic        inh_n_i,
  input  wire oitc_src_t   trig_src_i,
  input  wire logic        trig_dir_out_i,
  input  wire logic        trig_n_i,
  input  wire logic        bus_trig_i,
  input  wire logic        key_trig_i,
  input  wire logic        key_lock_i,
  input  wire logic        key_onoff_i,
  input  wire logic        key_clear_i,
  input  wire logic        key_shift_i,
  input  wire logic        key_other_i,
  input  wire logic        disch_en_i,
  output logic             out_on_o,
  output logic             load_en_o,
  output logic             lock_o,
  output logic             list_start_o,
  output logic             trig_n_o,
  output logic             trig_oe_o,
  output logic             key_other_o,
  output logic             key_shift_o,
  output logic             fb_trip_o,
  output logic             inh_latched_o
);
  typedef struct packed {
    logic [1:0]  inh_s;
    logic [1:0]  trg_s;
    logic        trg_p;
    logic        cc_prev;
    logic        fb_arm;
    logic [13:0] ms_cnt;
    logic [15:0] div;
    logic        on;
    logic        fb_trip;
    logic        inh_lat;
    logic        clr_seen;
    logic        lock;
    logic        start;
    logic [15:0] pulse;
    logic        oth;
    logic        sh;
    logic        load;
  } oitc_st_t;

  oitc_st_t st_q;
  oitc_st_t st_d;
  logic     inh_lo;
  logic     ext_fall;
  logic     fb_edge;
  logic     key_ok;
  logic     trig_acc;
  logic     out_eff;

  assign inh_lo   = ~st_q.inh_s[1];
  // Edge taken past the synchroniser, so the first flop is never read twice
  assign ext_fall = st_q.trg_p & ~st_q.trg_s[1];

  always_comb
  begin
    st_d = st_q;
    st_d.inh_s = {st_q.inh_s[0], inh_n_i};
    st_d.trg_s = {st_q.trg_s[0], trig_n_i};
    st_d.trg_p = st_q.trg_s[1];
    st_d.cc_prev = reg_cc_i;
    st_d.start = 1'b0;
    // Locked panel ignores everything but on/off, shift and the lock key
    key_ok = ~st_q.lock;
    st_d.oth = key_other_i & key_ok;
    st_d.sh = key_shift_i;
    if (key_lock_i)
      st_d.lock = ~st_q.lock;
    fb_edge = 1'b0;
    if (fb_mode_i == OITC_FB_CC)
      fb_edge = reg_cc_i & ~st_q.cc_prev;
    else if (fb_mode_i == OITC_FB_CV)
      fb_edge = ~reg_cc_i & st_q.cc_prev;
    // Delay counts from the regime change; reverting cancels it
    if (fb_mode_i == OITC_FB_OFF)
      st_d.fb_arm = 1'b0;
    else if (fb_edge)
    begin
      st_d.fb_arm = 1'b1;
      st_d.ms_cnt = '0;
      st_d.div = '0;
    end
    else if (st_q.fb_arm)
    begin
      if ((fb_mode_i == OITC_FB_CC) != reg_cc_i)
        st_d.fb_arm = 1'b0;
      else if (st_q.ms_cnt >= fb_delay_ms_i)
      begin
        st_d.fb_arm = 1'b0;
        st_d.fb_trip = 1'b1;
        st_d.on = 1'b0;
      end
      else if (st_q.div == 16'(STEP_CYC - 1))
      begin
        st_d.div = '0;
        st_d.ms_cnt = st_q.ms_cnt + 14'h0001;
      end
      else
        st_d.div = st_q.div + 16'h0001;
    end
    if (inh_mode_i == OITC_INH_LATCH && inh_lo)
    begin
      st_d.inh_lat = 1'b1;
      st_d.on = 1'b0;
      st_d.clr_seen = 1'b0;
    end
    else if (st_q.inh_lat && key_clear_i && key_ok)
      st_d.clr_seen = 1'b1;
    if (key_onoff_i)
    begin
      if (st_q.on)
        st_d.on = 1'b0;
      else if ((!st_q.inh_lat || (st_q.clr_seen && !inh_lo))
               && !(inh_mode_i == OITC_INH_LATCH && inh_lo))
      begin
        st_d.on = 1'b1;
        st_d.inh_lat = 1'b0;
        st_d.clr_seen = 1'b0;
        st_d.fb_trip = 1'b0;
      end
    end
    trig_acc = 1'b0;
    case (trig_src_i)
      OITC_SRC_KEY: trig_acc = key_trig_i & key_ok;
      OITC_SRC_BUS: trig_acc = bus_trig_i;
      OITC_SRC_EXT: trig_acc = ~trig_dir_out_i & ext_fall;
      default:      trig_acc = 1'b0;
    endcase
    st_d.start = trig_acc;
    if (trig_acc && trig_dir_out_i && trig_src_i != OITC_SRC_EXT)
      st_d.pulse = 16'(PULSE_CYC);
    else if (st_q.pulse != 16'h0000)
      st_d.pulse = st_q.pulse - 16'h0001;
    out_eff = st_d.on & ~(inh_mode_i == OITC_INH_LIVE & inh_lo);
    st_d.load = disch_en_i & ~out_eff;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
      st_q.inh_s <= 2'b11;
      st_q.trg_s <= 2'b11;
      st_q.trg_p <= 1'b1;
      st_q.load <= OITC_DISCH_RST;
    end
    else
      st_q <= st_d;
  end

  assign out_on_o      = st_q.on & ~(inh_mode_i == OITC_INH_LIVE & inh_lo);
  assign load_en_o     = st_q.load;
  assign lock_o        = st_q.lock;
  assign list_start_o  = st_q.start;
  assign trig_n_o      = 1'b0;
  assign trig_oe_o     = trig_dir_out_i & (st_q.pulse != 16'h0000);
  assign key_other_o   = st_q.oth;
  assign key_shift_o   = st_q.sh;
  assign fb_trip_o     = st_q.fb_trip;
  assign inh_latched_o = st_q.inh_lat;

  AST_LIVE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    inh_mode_i == OITC_INH_LIVE && inh_lo |-> !out_on_o)
    else $error("output on while living disable low");
  AST_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    inh_mode_i == OITC_INH_LATCH && inh_lo |=> !st_q.on && st_q.inh_lat)
    else $error("latch disable did not turn output off");
  AST_NO_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.inh_lat && !key_onoff_i |=> !st_q.on)
    else $error("latched output restored without on command");
  AST_FB_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    fb_mode_i == OITC_FB_OFF |=> !st_q.fb_arm)
    else $error("foldback armed while disabled");
  AST_FB_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.fb_arm && fb_delay_ms_i == 14'h0000 && fb_mode_i == OITC_FB_CC
    && reg_cc_i |=> st_q.fb_trip && !st_q.on)
    else $error("zero delay foldback did not trip");
  sequence oitc_ext_fall_s;
    trig_src_i == OITC_SRC_EXT && !trig_dir_out_i && $fell(st_q.trg_s[1]);
  endsequence

  AST_EXT: assert property (@(posedge clk_i) disable iff (rst_i)
    oitc_ext_fall_s |=> list_start_o)
    else $error("external falling edge gave no start");
  AST_EXT_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_src_i == OITC_SRC_EXT && st_q.pulse == 16'h0000 |=> !trig_oe_o)
    else $error("trigger pin driven with external source");
  AST_KEY_LOCKED: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.lock && trig_src_i == OITC_SRC_KEY |=> !list_start_o)
    else $error("key trigger accepted while locked");
  AST_LIVE_BACK: assert property (@(posedge clk_i) disable iff (rst_i)
    inh_mode_i == OITC_INH_LIVE && !inh_lo && st_q.on |-> out_on_o)
    else $error("output not restored after living disable");
  AST_CLR_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.inh_lat && !st_q.clr_seen |=> !st_q.on)
    else $error("latched output on without clear key");
  AST_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    list_start_o && trig_dir_out_i && trig_src_i != OITC_SRC_EXT
    |-> trig_oe_o)
    else $error("no trigger pulse driven out");
  AST_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.lock && !key_lock_i |=> !key_other_o)
    else $error("key passed while locked");
  AST_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    !disch_en_i |=> !load_en_o)
    else $error("load enabled while discharge off");
  AST_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    list_start_o |=> !list_start_o)
    else $error("trigger event longer than one cycle");
endmodule

// >>> bench/oitc_far_end.sv
`timescale 1ns/1ns
module oitc_far_end #(
  parameter int unsigned LEN = 5
)(
  input  wire logic clk_i,
  input  wire logic fire_i,
  input  wire logic short_i,
  output logic      trig_oe_o,
  output logic      inh_n_o
);
  int unsigned cnt_q = 0;
  // Open drain: pulls low for LEN cycles, else lets the pull-up win
  always_ff @(posedge clk_i)
    cnt_q <= fire_i ? LEN : ((cnt_q != 0) ? cnt_q - 1 : 0);
  assign trig_oe_o = (cnt_q != 0);
  assign inh_n_o   = ~short_i;
endmodule

// >>> bench/oitc_ctrl_test.sv
`timescale 1ns/1ns
module oitc_ctrl_test
  import oitc_pkg::*;
;
  localparam logic [4:0] K_CLR = 5'h01, K_ON = 5'h02, K_LCK = 5'h04;
  localparam logic [4:0] K_TRG = 5'h08, K_BUS = 5'h10;
  logic        clk_i = 1'b0, rst_i = 1'b1, reg_cc_i = 1'b0;
  oitc_fb_t    fb_mode_i = OITC_FB_OFF;
  oitc_inh_t   inh_mode_i = OITC_INH_OFF;
  oitc_src_t   trig_src_i = OITC_SRC_KEY;
  logic [13:0] fb_delay_ms_i = 14'h0000;
  logic        trig_dir_out_i = 1'b1, disch_en_i = 1'b1;
  logic        key_shift_i = 1'b0, key_other_i = 1'b0;
  logic        fire = 1'b0, short_inh = 1'b0;
  logic [4:0]  kp = 5'h00;
  logic [7:0]  lfsr = 8'h04;
  logic        out_on_o, load_en_o, lock_o, list_start_o, trig_n_o;
  logic        trig_oe_o, key_other_o, key_shift_o, fb_trip_o, inh_latched_o;
  wire         bus_trig_i, key_trig_i, key_lock_i, key_onoff_i, key_clear_i;
  wire         trig_n_i, inh_n_i, far_oe;
  int          bad_count = 0, checked = 0, ncyc = 0, d;
  int          exp_q[$];
  assign {bus_trig_i, key_trig_i, key_lock_i, key_onoff_i, key_clear_i} = kp;
  // Shared pin with pull-up: low when either end pulls it down
  assign trig_n_i = ~((trig_oe_o & ~trig_n_o) | far_oe);
  oitc_ctrl #(.STEP_CYC(4), .PULSE_CYC(3)) u_dut (
    .clk_i, .rst_i, .fb_mode_i, .fb_delay_ms_i, .reg_cc_i, .inh_mode_i,
    .inh_n_i, .trig_src_i, .trig_dir_out_i, .trig_n_i, .bus_trig_i,
    .key_trig_i, .key_lock_i, .key_onoff_i, .key_clear_i, .key_shift_i,
    .key_other_i, .disch_en_i, .out_on_o, .load_en_o, .lock_o,
    .list_start_o, .trig_n_o, .trig_oe_o, .key_other_o, .key_shift_o,
    .fb_trip_o, .inh_latched_o);
  oitc_far_end #(.LEN(5)) u_far (.clk_i, .fire_i(fire), .short_i(short_inh),
    .trig_oe_o(far_oe), .inh_n_o(inh_n_i));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Idle cycle after each press so the strobe is never re-driven at once
  task automatic press(input logic [4:0] m);
    kp <= m;
    tick(1);
    kp <= 5'h00;
    tick(1);
  endtask
  task automatic check(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: level %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic check_cyc(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      bad_count++;
      $display("ERROR %0t: start at %0d, expected %0d", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always #25 clk_i = ~clk_i;
  always @(negedge clk_i)
  begin
    if (list_start_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        exp_q.push_back(-1);
      check_cyc(ncyc, exp_q.pop_front());
    end
    ncyc++;
  end
  initial
  begin
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    check(out_on_o, 0);
    check(load_en_o, 1);
    for (int i = 0; i < 2; i++)
    begin
      lfsr = lfsr_next(lfsr);
      d = 1 + lfsr[2:0];
      fb_delay_ms_i <= 14'(d);
      fb_mode_i <= i ? OITC_FB_CV : OITC_FB_CC;
      press(K_ON);
      tick(4);
      check(out_on_o, 1);
      reg_cc_i <= ~reg_cc_i;
      tick(4 * d - 1);
      check(out_on_o, 1);
      tick(6);
      check(out_on_o, 0);
      check(fb_trip_o, 1);
    end
    fb_mode_i <= OITC_FB_OFF;
    press(K_ON);
    reg_cc_i <= ~reg_cc_i;
    tick(40);
    check(out_on_o, 1);
    inh_mode_i <= OITC_INH_LATCH;
    short_inh <= 1'b1;
    tick(6);
    check(inh_latched_o, 1);
    short_inh <= 1'b0;
    tick(6);
    check(out_on_o, 0);
    press(K_ON);
    tick(4);
    check(out_on_o, 0);
    press(K_CLR);
    press(K_ON);
    tick(4);
    check(out_on_o, 1);
    inh_mode_i <= OITC_INH_LIVE;
    short_inh <= 1'b1;
    tick(6);
    check(out_on_o, 0);
    check(load_en_o, 1);
    disch_en_i <= 1'b0;
    tick(3);
    check(load_en_o, 0);
    short_inh <= 1'b0;
    tick(6);
    check(out_on_o, 1);
    press(K_LCK);
    key_other_i <= 1'b1;
    key_shift_i <= 1'b1;
    tick(3);
    check(lock_o, 1);
    check(key_other_o, 0);
    check(key_shift_o, 1);
    press(K_TRG);
    press(K_ON);
    tick(3);
    check(out_on_o, 0);
    press(K_LCK);
    tick(3);
    check(key_other_o, 1);
    for (int i = 0; i < 2; i++)
    begin
      trig_src_i <= i ? OITC_SRC_BUS : OITC_SRC_KEY;
      exp_q.push_back(ncyc + 1);
      press(K_TRG | K_BUS);
      check(trig_oe_o, 1);
      tick(3);
      check(trig_oe_o, 0);
    end
    trig_src_i <= OITC_SRC_EXT;
    trig_dir_out_i <= 1'b0;
    press(K_BUS);
    exp_q.push_back(ncyc + 4);
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    tick(20);
    check(exp_q.size() == 0, 1);
    give_verdict();
  end
  initial
  begin
    #(2000 * 50);
    bad_count++;
    give_verdict();
  end
endmodule
